// ---- rtl/fpm_cfg.svh ----
// constants for the flash program mode controller
// Operation
// - flash is written one byte or up to 32 bytes in one row operation
// - erasing or writing one sector never touches any other sector
// - first sector size comes from the option byte field, not fixed
// - in programming socket all sectors, option row and eeprom alterable
// - in circuit programming alters all sectors, option row and eeprom
// - self programming alters only second sector and eeprom, blocks rest
// - tool sends entry pattern on clock and data pins while reset low
// - comm mode boots from system memory vector instead of user vector
// - tool sends driver bytes serially on data pin, stored in ram
// - after download the driver runs from ram and programs the flash
// - permanent write lock refuses all program memory change, cleared only by reset
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH
`define FPM_VECTOR_USER    16'hFFFE
`define FPM_VECTOR_SYSMEM  16'hEFFE
`define FPM_RAM_BASE       16'h0080
`define FPM_ENTRY_KEY      8'hA5
`define FPM_ENTRY_BITS     4'h8
`define FPM_ROW_BYTES      7'h20
`define FPM_S0_BASE_0      16'hFE00
`define FPM_S0_BASE_1      16'hFC00
`define FPM_S0_BASE_2      16'hF800
`define FPM_S0_BASE_3      16'hF000
`define FPM_SPACE_FLASH    2'h0
`define FPM_SPACE_OPTION   2'h1
`define FPM_SPACE_EEPROM   2'h2
`endif

// ---- rtl/fpm_pkg.sv ----
// types shared by the flash program mode controller
package fpm_pkg;
  typedef enum logic [1:0] {
    FPM_BOOT_USER   = 2'b00,
    FPM_BOOT_SOCKET = 2'b01,
    FPM_BOOT_COMM   = 2'b10
  } fpm_boot_t;

  typedef enum logic [1:0] {
    FPM_REG_SEC0   = 2'b00,
    FPM_REG_SEC1   = 2'b01,
    FPM_REG_OPTION = 2'b10,
    FPM_REG_EEPROM = 2'b11
  } fpm_region_t;

  typedef enum logic [1:0] {
    FPM_DL_LEN  = 2'b00,
    FPM_DL_DATA = 2'b01,
    FPM_DL_DONE = 2'b10
  } fpm_dl_t;
endpackage

// ---- rtl/fpm_ram.sv ----
// driver download ram with registered read data
`timescale 1ns/10ps
module fpm_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;

  // array itself has no reset, contents come from the download
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_reg <= mem[rd_addr];
  end

  assign rd_data = rd_data_reg;
endmodule // fpm_ram

// ---- rtl/fpm_top.sv ----
// flash program mode control: boot mode entry, driver download, write gate
`timescale 1ns/10ps
`include "fpm_cfg.svh"
module fpm_top
  import fpm_pkg::*;
#(
  parameter int RAM_DEPTH = 256,
  parameter int RAM_AW    = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              reset_pin_n,
  input  wire logic              comm_serial_clock_pin,
  input  wire logic              comm_serial_data_pin,
  input  wire logic              socket_strap,
  input  wire logic              self_prog_enable,
  input  wire logic              permanent_write_lock_bit,
  input  wire logic [1:0]        sector0_size_opt,
  input  wire logic              prog_req,
  input  wire logic              prog_erase,
  input  wire logic [1:0]        prog_space,
  input  wire logic [15:0]       prog_addr,
  input  wire logic [5:0]        prog_count,
  input  wire logic [RAM_AW-1:0] ram_rd_addr,
  output logic      [7:0]        ram_rd_data,
  output logic                   cpu_hold,
  output logic      [1:0]        boot_mode,
  output logic      [15:0]       boot_vector,
  output logic                   run_from_ram,
  output logic      [15:0]       exec_addr,
  output logic                   prog_grant,
  output logic                   prog_refuse,
  output logic      [3:0]        prog_region_sel,
  output logic                   prog_erase_out,
  output logic      [15:0]       prog_addr_out,
  output logic      [5:0]        prog_count_out,
  output logic                   write_locked
);

  // three-stage synchronisers for the pins, stage one feeds stage two only
  logic [2:0] rst_sync_reg, clk_sync_reg, dat_sync_reg;
  logic       rst_stable_reg, rst_stable_next;
  logic       clk_stable_reg, clk_stable_next;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rst_sync_reg <= 3'h0;
      clk_sync_reg <= 3'h7;
      dat_sync_reg <= 3'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[1:0], reset_pin_n};
      clk_sync_reg <= {clk_sync_reg[1:0], comm_serial_clock_pin};
      dat_sync_reg <= {dat_sync_reg[1:0], comm_serial_data_pin};
    end
  end

  // a level counts once stages two and three agree
  logic pin_release, pin_low, link_rise;
  always_comb begin
    rst_stable_next = rst_stable_reg;
    clk_stable_next = clk_stable_reg;
    if (rst_sync_reg[1] == rst_sync_reg[2]) begin
      rst_stable_next = rst_sync_reg[2];
    end
    if (clk_sync_reg[1] == clk_sync_reg[2]) begin
      clk_stable_next = clk_sync_reg[2];
    end
    pin_release = rst_stable_next & ~rst_stable_reg;
    pin_low     = ~rst_stable_reg;
    link_rise   = clk_stable_next & ~clk_stable_reg;
  end

  // idle clock pin reads high thanks to the pull-up
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rst_stable_reg <= 1'b0;
      clk_stable_reg <= 1'b1;
    end else begin
      rst_stable_reg <= rst_stable_next;
      clk_stable_reg <= clk_stable_next;
    end
  end

  // entry pattern shifter and boot mode latch
  fpm_boot_t  mode_reg, mode_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bits_reg, bits_next;
  logic       lock_reg, lock_next;
  logic       entry_ok;

  always_comb begin
    mode_next  = mode_reg;
    shift_next = shift_reg;
    bits_next  = bits_reg;
    entry_ok   = (shift_reg == `FPM_ENTRY_KEY) &&
                 (bits_reg >= `FPM_ENTRY_BITS);
    // lock only ever sets, nothing but reset clears it
    lock_next  = lock_reg | permanent_write_lock_bit;
    if (link_rise) begin
      shift_next = {shift_reg[6:0], dat_sync_reg[2]};
      // wrap back to eight so the low bits keep framing download bytes
      if (bits_reg != 4'hF) begin
        bits_next = bits_reg + 4'h1;
      end else begin
        bits_next = `FPM_ENTRY_BITS;
      end
    end
    if (pin_low) begin
      mode_next = FPM_BOOT_USER;
    end
    if (pin_release) begin
      // mode frozen here until the next reset pin assertion
      if (entry_ok) begin
        mode_next = FPM_BOOT_COMM;
      end else if (socket_strap) begin
        mode_next = FPM_BOOT_SOCKET;
      end else begin
        mode_next = FPM_BOOT_USER;
      end
      shift_next = 8'h00;
      bits_next  = 4'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_reg  <= FPM_BOOT_USER;
      shift_reg <= 8'h00;
      bits_reg  <= 4'h0;
      lock_reg  <= 1'b0;
    end else begin
      mode_reg  <= mode_next;
      shift_reg <= shift_next;
      bits_reg  <= bits_next;
      lock_reg  <= lock_next;
    end
  end

  // driver download into ram, first byte is the length
  fpm_dl_t         dl_reg, dl_next;
  logic [7:0]      len_reg, len_next;
  logic [7:0]      waddr_reg, waddr_next;
  logic            run_reg, run_next;
  logic            ram_we;
  logic            byte_done;
  logic [7:0]      byte_val;

  always_comb begin
    dl_next    = dl_reg;
    len_next   = len_reg;
    waddr_next = waddr_reg;
    run_next   = run_reg;
    ram_we     = 1'b0;
    byte_val   = {shift_reg[6:0], dat_sync_reg[2]};
    byte_done  = link_rise && (bits_reg[2:0] == 3'h7) && !pin_low &&
                 (mode_reg == FPM_BOOT_COMM);
    unique case (dl_reg)
      FPM_DL_LEN: begin
        if (byte_done) begin
          len_next = byte_val;
          dl_next  = (byte_val == 8'h00) ? FPM_DL_DONE : FPM_DL_DATA;
        end
      end
      FPM_DL_DATA: begin
        if (byte_done) begin
          ram_we     = 1'b1;
          waddr_next = waddr_reg + 8'h01;
          if (waddr_next == len_reg) begin
            dl_next = FPM_DL_DONE;
          end
        end
      end
      FPM_DL_DONE: begin
        run_next = 1'b1;
      end
      default: dl_next = FPM_DL_LEN;
    endcase
    if (pin_low) begin
      dl_next    = FPM_DL_LEN;
      waddr_next = 8'h00;
      run_next   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dl_reg    <= FPM_DL_LEN;
      len_reg   <= 8'h00;
      waddr_reg <= 8'h00;
      run_reg   <= 1'b0;
    end else begin
      dl_reg    <= dl_next;
      len_reg   <= len_next;
      waddr_reg <= waddr_next;
      run_reg   <= run_next;
    end
  end

  fpm_ram #(
    .WIDTH (8),
    .DEPTH (RAM_DEPTH),
    .AW    (RAM_AW)
  ) u_ram (
    .sys_clk (sys_clk),
    .wr_en   (ram_we),
    .wr_addr (RAM_AW'(waddr_reg)),
    .wr_data (byte_val),
    .rd_addr (ram_rd_addr),
    .rd_data (ram_rd_data)
  );

  // region decode and permission check for each request
  logic [15:0]  s0_base;
  fpm_region_t  region;
  logic [6:0]   row_end;
  logic         count_ok, mode_ok, lock_ok;
  logic [3:0]   sel_onehot;

  always_comb begin
    unique case (sector0_size_opt)
      2'h0: s0_base = `FPM_S0_BASE_0;
      2'h1: s0_base = `FPM_S0_BASE_1;
      2'h2: s0_base = `FPM_S0_BASE_2;
      2'h3: s0_base = `FPM_S0_BASE_3;
    endcase
    if (prog_space == `FPM_SPACE_OPTION) begin
      region = FPM_REG_OPTION;
    end else if (prog_space == `FPM_SPACE_EEPROM) begin
      region = FPM_REG_EEPROM;
    end else if (prog_addr >= s0_base) begin
      region = FPM_REG_SEC0;
    end else begin
      region = FPM_REG_SEC1;
    end
    // a burst stays inside one 32-byte row
    row_end  = {2'b00, prog_addr[4:0]} + {1'b0, prog_count};
    count_ok = (prog_count != 6'h00) && (row_end <= `FPM_ROW_BYTES);
    unique case (mode_reg)
      FPM_BOOT_SOCKET: mode_ok = 1'b1;
      FPM_BOOT_COMM:   mode_ok = 1'b1;
      default: mode_ok = self_prog_enable && ((region == FPM_REG_SEC1) ||
                         (region == FPM_REG_EEPROM));
    endcase
    // eeprom data is outside the permanent lock
    lock_ok = !lock_reg || (region == FPM_REG_EEPROM);
  end

  // one select line per region, never more than one at a time
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sel
      assign sel_onehot[gi] = (region == fpm_region_t'(gi));
    end
  endgenerate

  logic        grant_reg, grant_next;
  logic        refuse_reg, refuse_next;
  logic [3:0]  sel_reg, sel_next;
  logic        erase_reg, erase_next;
  logic [15:0] paddr_reg, paddr_next;
  logic [5:0]  pcnt_reg, pcnt_next;

  // decision is a one-cycle pulse, target fields hold until next request
  always_comb begin
    grant_next  = 1'b0;
    refuse_next = 1'b0;
    sel_next    = sel_reg;
    erase_next  = erase_reg;
    paddr_next  = paddr_reg;
    pcnt_next   = pcnt_reg;
    if (prog_req) begin
      if (count_ok && mode_ok && lock_ok && !pin_low) begin
        grant_next = 1'b1;
        sel_next   = sel_onehot;
        erase_next = prog_erase;
        paddr_next = prog_addr;
        pcnt_next  = prog_count;
      end else begin
        refuse_next = 1'b1;
        sel_next    = 4'h0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      grant_reg  <= 1'b0;
      refuse_reg <= 1'b0;
      sel_reg    <= 4'h0;
      erase_reg  <= 1'b0;
      paddr_reg  <= 16'h0000;
      pcnt_reg   <= 6'h00;
    end else begin
      grant_reg  <= grant_next;
      refuse_reg <= refuse_next;
      sel_reg    <= sel_next;
      erase_reg  <= erase_next;
      paddr_reg  <= paddr_next;
      pcnt_reg   <= pcnt_next;
    end
  end

  // vector and status outputs straight from registers, exec_addr fixed at the ram base
  logic [15:0] vec_reg, vec_next;
  logic        hold_reg, hold_next;
  always_comb begin
    vec_next  = (mode_next == FPM_BOOT_COMM) ? `FPM_VECTOR_SYSMEM
                                             : `FPM_VECTOR_USER;
    hold_next = !rst_stable_next;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      vec_reg  <= `FPM_VECTOR_USER;
      hold_reg <= 1'b1;
    end else begin
      vec_reg  <= vec_next;
      hold_reg <= hold_next;
    end
  end

  assign cpu_hold        = hold_reg;
  assign boot_mode       = mode_reg;
  assign boot_vector     = vec_reg;
  assign run_from_ram    = run_reg;
  assign exec_addr       = `FPM_RAM_BASE;
  assign prog_grant      = grant_reg;
  assign prog_refuse     = refuse_reg;
  assign prog_region_sel = sel_reg;
  assign prog_erase_out  = erase_reg;
  assign prog_addr_out   = paddr_reg;
  assign prog_count_out  = pcnt_reg;
  assign write_locked    = lock_reg;
endmodule // fpm_top

// ---- verification/fpm_tool_model.sv ----
// programming tool model on the reset and link pins
`timescale 1ns/10ps
module fpm_tool_model (
  output logic reset_pin_n,
  output logic comm_serial_clock_pin,
  output logic comm_serial_data_pin
);
  // idle: reset released, clock held high by the pull-up
  initial begin
    reset_pin_n = 1'b1;
    comm_serial_clock_pin = 1'b1;
    comm_serial_data_pin = 1'b0;
  end

  // one byte msb first, 160 ns a bit, then optional idle
  task automatic send(input logic [7:0] b, input int idle);
    for (int i = 7; i >= 0; i--) begin
      comm_serial_clock_pin = 1'b0;
      comm_serial_data_pin = b[i];
      #80;
      comm_serial_clock_pin = 1'b1;
      #80;
    end
    // released data line must not keep its last level
    comm_serial_data_pin = ~comm_serial_data_pin;
    #idle;
  endtask

  // key shifted in while the reset pin is held low
  task automatic enter(input logic [7:0] k);
    reset_pin_n = 1'b0;
    #300;
    send(k, 300);
    reset_pin_n = 1'b1;
  endtask
endmodule // fpm_tool_model

// ---- verification/fpm_top_checker.sv ----
// port assertions for the flash program mode controller
`timescale 1ns/10ps
module fpm_top_checker
  import fpm_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        permanent_write_lock_bit,
  input wire logic [1:0]  sector0_size_opt,
  input wire logic        prog_req,
  input wire logic [1:0]  prog_space,
  input wire logic [15:0] prog_addr,
  input wire logic [5:0]  prog_count,
  input wire logic        cpu_hold,
  input wire logic [1:0]  boot_mode,
  input wire logic [15:0] boot_vector,
  input wire logic        run_from_ram,
  input wire logic [15:0] exec_addr,
  input wire logic        prog_grant,
  input wire logic        prog_refuse,
  input wire logic        write_locked
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // sector 0 base and bad row, worked out apart from the design
  logic [15:0] s0_base;
  logic        row_bad;
  assign s0_base = 16'hFE00 << sector0_size_opt;
  assign row_bad = prog_count == 6'h00 ||
                   {2'b00, prog_addr[4:0]} + {1'b0, prog_count} > 7'h20;

  // request answers, one cycle after the request
  a_answer_once: assert property (prog_req |=> prog_grant ^ prog_refuse)
    else $error("request not answered by one pulse");
  a_row_refused: assert property (prog_req && row_bad |=> prog_refuse)
    else $error("bad count or row crossing granted");
  a_user_blocks: assert property (prog_req && boot_mode == FPM_BOOT_USER &&
    (prog_space == 2'h1 || (prog_space == 2'h0 && prog_addr >= s0_base))
    |=> prog_refuse) else $error("user mode altered sector 0 or option");
  a_tool_grants: assert property (prog_req && boot_mode != FPM_BOOT_USER &&
    !row_bad && !cpu_hold && !write_locked && !permanent_write_lock_bit
    |=> prog_grant) else $error("tool mode request refused");
  // lock: refuses program memory, never lets go
  a_lock_refuses: assert property (prog_req && write_locked &&
    prog_space != 2'h2 |=> prog_refuse) else $error("locked write granted");
  a_lock_sticky: assert property (write_locked |=> write_locked)
    else $error("write lock dropped");
  // boot mode, vector and ram execution
  a_vector_mode: assert property (boot_vector ==
    (boot_mode == FPM_BOOT_COMM ? 16'hEFFE : 16'hFFFE))
    else $error("boot vector does not match mode");
  a_mode_held: assert property (!cpu_hold [*4] |-> $stable(boot_mode))
    else $error("boot mode changed outside reset");
  a_ram_exec: assert property (run_from_ram |->
    boot_mode == FPM_BOOT_COMM && exec_addr == 16'h0080)
    else $error("ram execution outside comm mode");
endmodule // fpm_top_checker

bind fpm_top fpm_top_checker i_fpm_top_checker (
  .sys_clk, .reset, .permanent_write_lock_bit, .sector0_size_opt,
  .prog_req, .prog_space, .prog_addr, .prog_count, .cpu_hold, .boot_mode,
  .boot_vector, .run_from_ram, .exec_addr, .prog_grant, .prog_refuse,
  .write_locked
);

// ---- verification/testbench.sv ----
// self-checking bench for the flash program mode controller
`timescale 1ns/10ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        socket_strap = 1'b0;
  logic        self_prog_enable = 1'b0;
  logic        permanent_write_lock_bit = 1'b0;
  logic [1:0]  sector0_size_opt = 2'h0;
  logic        prog_req = 1'b0;
  logic        prog_erase = 1'b0;
  logic [1:0]  prog_space = 2'h0;
  logic [15:0] prog_addr = 16'h0000;
  logic [5:0]  prog_count = 6'h00;
  logic [7:0]  ram_rd_addr = 8'h00;
  logic [1:0]  mode = 2'h0;
  logic        lk = 1'b0;
  int          err_total = 0;
  int          samples_checked = 0;
  wire         reset_pin_n, comm_serial_clock_pin, comm_serial_data_pin;
  wire         cpu_hold, run_from_ram, prog_grant, prog_refuse;
  wire         prog_erase_out, write_locked;
  wire  [7:0]  ram_rd_data;
  wire  [1:0]  boot_mode;
  wire  [3:0]  prog_region_sel;
  wire  [5:0]  prog_count_out;
  wire  [15:0] boot_vector, exec_addr, prog_addr_out;

  fpm_tool_model i_fpm_tool_model (.reset_pin_n, .comm_serial_clock_pin,
    .comm_serial_data_pin);
  fpm_top i_fpm_top (.sys_clk, .reset, .reset_pin_n, .comm_serial_clock_pin,
    .comm_serial_data_pin, .socket_strap, .self_prog_enable,
    .permanent_write_lock_bit, .sector0_size_opt, .prog_req, .prog_erase,
    .prog_space, .prog_addr, .prog_count, .ram_rd_addr, .ram_rd_data,
    .cpu_hold, .boot_mode, .boot_vector, .run_from_ram, .exec_addr,
    .prog_grant, .prog_refuse, .prog_region_sel, .prog_erase_out,
    .prog_addr_out, .prog_count_out, .write_locked);

  initial forever #10 sys_clk = ~sys_clk;

  task automatic close_out();
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // region one-hot: sector 0 from the option base upward
  function automatic logic [3:0] region(input logic [1:0] sp,
                                        input logic [15:0] a);
    if (sp != 2'h0)
      return (sp == 2'h1) ? 4'h4 : 4'h8;
    return (a >= (16'hFE00 << sector0_size_opt)) ? 4'h1 : 4'h2;
  endfunction

  // whether the current mode and lock let the request through
  function automatic logic allow(input logic [3:0] r, input logic [15:0] a,
                                 input logic [5:0] n);
    if (n == 6'h00 || {2'b00, a[4:0]} + {1'b0, n} > 7'h20)
      return 1'b0;
    if (lk && r != 4'h8)
      return 1'b0;
    if (mode == 2'h0)
      return self_prog_enable && (r[1] || r[3]);
    return 1'b1;
  endfunction

  // one request pulse, answer checked one cycle on
  task automatic req(input logic [1:0] sp, input logic [15:0] a,
                     input logic [5:0] n);
    logic [3:0] r;
    logic       g;
    logic       e;
    @(posedge sys_clk);
    r = region(sp, a);
    g = allow(r, a, n);
    e = 1'($urandom);
    prog_req <= 1'b1;
    prog_space <= sp;
    prog_addr <= a;
    prog_count <= n;
    prog_erase <= e;
    @(posedge sys_clk);
    prog_req <= 1'b0;
    #1;
    chk("grant", 16'(g), 16'(prog_grant));
    chk("refuse", 16'(!g), 16'(prog_refuse));
    chk("region", g ? 16'(r) : 16'h0000, 16'(prog_region_sel));
    if (g) begin
      chk("addr", a, prog_addr_out);
      chk("count", 16'(n), 16'(prog_count_out));
      chk("erase", 16'(e), 16'(prog_erase_out));
    end
  endtask

  // random requests; wrong counts and row crossings included
  task automatic req_rand(input int cnt);
    repeat (cnt) req(2'($urandom_range(0, 2)), 16'($urandom),
                     6'($urandom_range(0, 33)));
  endtask

  // reset pin pulse with a key, wrong unless comm mode is wanted
  task automatic boot(input logic [1:0] m);
    logic [7:0] k;
    k = (m == 2'h2) ? 8'hA5 : 8'h5A ^ 8'($urandom_range(0, 254));
    @(posedge sys_clk);
    socket_strap <= (m == 2'h1);
    i_fpm_tool_model.enter(k);
    repeat (8) @(posedge sys_clk);
    #1;
    mode = m;
    chk("mode", 16'(m), 16'(boot_mode));
    chk("vector", m[1] ? 16'hEFFE : 16'hFFFE, boot_vector);
    chk("hold", 16'h0000, 16'(cpu_hold));
  endtask

  // length byte then two driver bytes, slow gap before the last
  task automatic download();
    logic [7:0] b [2];
    b[0] = 8'($urandom);
    b[1] = 8'($urandom);
    i_fpm_tool_model.send(8'h02, 0);
    i_fpm_tool_model.send(b[0], 700);
    i_fpm_tool_model.send(b[1], 0);
    repeat (6) @(posedge sys_clk);
    #1;
    chk("run", 16'h0001, 16'(run_from_ram));
    chk("entry", 16'h0080, exec_addr);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      ram_rd_addr <= 8'(i);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("ram", 16'(b[i]), 16'(ram_rd_data));
    end
  endtask

  // main sequence
  initial begin
    void'($urandom(57208));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    for (int m = 1; m <= 2; m++) begin
      boot(2'(m));
      if (m == 2)
        download();
      req(2'h0, 16'hFFE0, 6'h20);
      req(2'h0, 16'hE001, 6'h20);
      req(2'h1, 16'h1000, 6'h01);
      req(2'h2, 16'h1010, 6'h00);
      req_rand(10);
    end
    boot(2'h0);
    req(2'h2, 16'h1000, 6'h01);
    self_prog_enable <= 1'b1;
    for (int o = 0; o < 4; o++) begin
      sector0_size_opt <= 2'(o);
      req(2'h0, 16'hFE00 << o, 6'h20);
      req(2'h0, (16'hFE00 << o) - 16'h0020, 6'h20);
    end
    req_rand(10);
    permanent_write_lock_bit <= 1'b1;
    lk = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("lock", 16'h0001, 16'(write_locked));
    permanent_write_lock_bit <= 1'b0;
    req_rand(10);
    close_out();
  end

  // about fifteen times the expected run
  initial begin
    #200000;
    err_total++;
    close_out();
  end
endmodule // testbench
